// file: design/cgrs_cfg.svh
// Clock guard and reset status: offsets, bit positions, reset values, timing counts
`ifndef CGRS_CFG_SVH
`define CGRS_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CGRS_STATUS_IDX 8'h25
`define CGRS_EVENT_IDX 8'h26
`define CGRS_MASK_IDX 8'h27

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CGRS_BIT_WDG 0
`define CGRS_BIT_BKACT 1
`define CGRS_BIT_IE 2
`define CGRS_BIT_LVD 4
`define CGRS_EV_ENTER 0
`define CGRS_EV_LEAVE 1
`define CGRS_EV_BLOCK 2
`define CGRS_EV_W 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CGRS_EVENT_RST 3'h0
`define CGRS_MASK_RST 3'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CGRS_CLK_PERIOD_NS 8
`define CGRS_MAIN_MIN_PERIOD_NS 40
`define CGRS_MIN_PERIOD_CYC \
   ((`CGRS_MAIN_MIN_PERIOD_NS + `CGRS_CLK_PERIOD_NS - 1) / `CGRS_CLK_PERIOD_NS)
`define CGRS_MISS_EDGES 2
`define CGRS_RECOVER_EDGES 4
`define CGRS_SPIKE_LIMIT 4

`endif

// file: design/cgrs_clock_monitor.sv
// Clock guard core: spike filter, loss detection and source switching
`default_nettype none

module cgrs_clock_monitor #(
   parameter logic [7:0] MIN_PERIOD_CYC = 8'h05,
   parameter logic [1:0] MISS_EDGES = 2'h2,
   parameter logic [3:0] RECOVER_EDGES = 4'h4,
   parameter logic [3:0] SPIKE_LIMIT = 4'h4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic guard_en_i,
   input wire logic freeze_i,
   // Synchronised oscillator edges
   input wire logic main_rise_i,
   input wire logic backup_rise_i,
   // Results
   output logic core_tick_o,
   output cgrs_pkg::cgrs_src_t src_o,
   output logic blocked_o,
   output logic enter_backup_o,
   output logic leave_backup_o,
   output logic block_start_o
);

   logic [7:0] gap_q;
   logic [3:0] spike_q;
   logic [3:0] good_q;
   logic [1:0] miss_q;
   logic good_edge;
   logic spike_edge;
   logic recovered;
   logic lost;
   logic run;

   assign run = guard_en_i & ~freeze_i;
   assign good_edge = main_rise_i & (gap_q >= MIN_PERIOD_CYC);
   assign spike_edge = main_rise_i & (gap_q < MIN_PERIOD_CYC);
   assign recovered = good_edge & (good_q == RECOVER_EDGES - 4'h1);
   assign lost = backup_rise_i & (miss_q == MISS_EDGES - 2'h1);

   // Cycles since last main edge of any kind, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || !guard_en_i) begin
         gap_q <= 8'h00;
      end else if (run) begin
         if (main_rise_i) begin
            gap_q <= 8'h00;
         end else if (gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h01;
         end
      end
   end

   // Run lengths of spikes and of good periods
   always_ff @(posedge clk_i) begin
      if (rst_i || !guard_en_i) begin
         spike_q <= 4'h0;
         good_q <= 4'h0;
      end else if (run) begin
         if (spike_edge) begin
            good_q <= 4'h0;
            if (spike_q != 4'hf) begin
               spike_q <= spike_q + 4'h1;
            end
         end else if (good_edge) begin
            spike_q <= 4'h0;
            if (good_q != 4'hf) begin
               good_q <= good_q + 4'h1;
            end
         end else if (backup_rise_i && miss_q != 2'h0) begin
            good_q <= 4'h0;
         end
      end
   end

   // Backup edges seen without a good main edge
   always_ff @(posedge clk_i) begin
      if (rst_i || !guard_en_i) begin
         miss_q <= 2'h0;
      end else if (run) begin
         if (good_edge) begin
            miss_q <= 2'h0;
         end else if (backup_rise_i && miss_q != MISS_EDGES) begin
            miss_q <= miss_q + 2'h1;
         end
      end
   end

   // Filter block and source selection
   always_ff @(posedge clk_i) begin
      if (rst_i || !guard_en_i) begin
         blocked_o <= 1'b0;
         block_start_o <= 1'b0;
         src_o <= cgrs_pkg::CGRS_ON_MAIN;
         enter_backup_o <= 1'b0;
         leave_backup_o <= 1'b0;
      end else begin
         block_start_o <= 1'b0;
         enter_backup_o <= 1'b0;
         leave_backup_o <= 1'b0;
         if (run) begin
            if (spike_edge && spike_q == SPIKE_LIMIT - 4'h1 && !blocked_o) begin
               blocked_o <= 1'b1;
               block_start_o <= 1'b1;
            end else if (recovered) begin
               blocked_o <= 1'b0;
            end
            unique case (src_o)
               cgrs_pkg::CGRS_ON_MAIN: begin
                  if (lost) begin
                     src_o <= cgrs_pkg::CGRS_ON_BACKUP;
                     enter_backup_o <= 1'b1;
                  end
               end
               cgrs_pkg::CGRS_ON_BACKUP: begin
                  if (recovered) begin
                     src_o <= cgrs_pkg::CGRS_ON_MAIN;
                     leave_backup_o <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Core clock tick from the selected source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_tick_o <= 1'b0;
      end else if (!guard_en_i) begin
         core_tick_o <= main_rise_i;
      end else if (freeze_i) begin
         core_tick_o <= 1'b0;
      end else if (src_o == cgrs_pkg::CGRS_ON_BACKUP) begin
         core_tick_o <= backup_rise_i;
      end else begin
         core_tick_o <= good_edge & ~blocked_o & ~recovered | good_edge & recovered;
      end
   end

endmodule : cgrs_clock_monitor

`default_nettype wire

// file: design/cgrs_pkg.sv
// Clock guard and reset status: shared types
`default_nettype none

package cgrs_pkg;

   // Source currently driving the core
   typedef enum logic [0:0] {
      CGRS_ON_MAIN = 1'b0,
      CGRS_ON_BACKUP = 1'b1
   } cgrs_src_t;

endpackage : cgrs_pkg

`default_nettype wire

// file: design/cgrs_top.sv
// Clock guard and reset status: pin sampling, registers, interrupt, top level
//
// What this block does
// - A strap option captured at reset enables or disables the whole clock guard.
// - Main clock edges closer than the least period are spikes and are dropped.
// - A run of spikes blocks the main clock; good periods end the block.
// - Main clock missing for a backup period switches the core to the backup.
// - Recovered main clock takes the core back from the backup automatically.
// - Entering backup sets the backup active flag at status bit 1.
// - Interrupt when flag set, enable bit 2 set, CPU mask clear.
// - Guard runs unchanged in wait; its interrupt wakes wait, never halt.
// - In halt the status is frozen and the guard and backup are off.
// - Halt exit resumes old setup; reset restarts from reset values.
// - Undervoltage flag set by that reset, cleared by writing zero, kept otherwise.
// - Undervoltage flag is meaningless when the detector option is off.
// - Reading status clears the backup flag only after the main clock recovered.
// - Guard option off holds the backup active flag at zero.
// - Watchdog flag set by watchdog reset, cleared by zero write, pin reset or undervoltage.
// - Flags encode source: pin x0, watchdog x1, undervoltage 10 (undervoltage flag kept through pin and watchdog resets).
// - Status resets with enable and backup flag zero, cause flags per source.
//
// Register access over Wishbone was decided locally.
`default_nettype none
`include "cgrs_cfg.svh"

module cgrs_top #(
   parameter logic [7:0] MIN_PERIOD_CYC = 8'(`CGRS_MIN_PERIOD_CYC),
   parameter logic [1:0] MISS_EDGES = 2'(`CGRS_MISS_EDGES),
   parameter logic [3:0] RECOVER_EDGES = 4'(`CGRS_RECOVER_EDGES),
   parameter logic [3:0] SPIKE_LIMIT = 4'(`CGRS_SPIKE_LIMIT)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Oscillator pins
   input wire logic main_osc_i,
   input wire logic backup_osc_i,
   // Configuration options
   input wire logic guard_option_i,
   input wire logic lvd_option_i,
   // Reset cause, valid while rst_i is high
   input wire logic lvd_reset_i,
   input wire logic wdg_reset_i,
   // CPU state
   input wire logic cpu_irq_mask_i,
   input wire logic wait_mode_i,
   input wire logic halt_mode_i,
   // Clock outputs
   output logic core_tick_o,
   output logic core_clk_sel_o,
   output logic filter_active_o,
   output logic backup_osc_en_o,
   // Interrupt and wake
   output logic irq_o,
   output logic wake_o
);

   localparam int NPIN = 2;

   // ----------------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------------
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_lvl;
   logic [NPIN-1:0] pin_prev;
   logic [NPIN-1:0] pin_rise;

   assign pin_raw = {backup_osc_i, main_osc_i};

   for (genvar g = 0; g < NPIN; g++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic prev_q;

      always_ff @(posedge clk_i) begin
         s1_q <= pin_raw[g];
         s2_q <= s1_q;
         s3_q <= s2_q;
      end

      // Level moves only once stages two and three agree
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            lvl_q <= 1'b0;
            prev_q <= 1'b0;
         end else begin
            if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
            prev_q <= lvl_q;
         end
      end

      assign pin_lvl[g] = lvl_q;
      assign pin_prev[g] = prev_q;
      assign pin_rise[g] = pin_lvl[g] & ~pin_prev[g];
   end

   // ----------------------------------------------------------------------------
   // Option capture and low power gating
   // ----------------------------------------------------------------------------
   logic guard_en_q;
   logic halt_q;
   logic run_en;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         guard_en_q <= guard_option_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= halt_mode_i;
      end
   end

   assign run_en = guard_en_q & ~halt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         backup_osc_en_o <= 1'b0;
      end else begin
         backup_osc_en_o <= guard_en_q & ~halt_mode_i;
      end
   end

   // ----------------------------------------------------------------------------
   // Clock monitor
   // ----------------------------------------------------------------------------
   cgrs_pkg::cgrs_src_t src;
   logic blocked;
   logic ev_enter;
   logic ev_leave;
   logic ev_block;

   cgrs_clock_monitor #(
      .MIN_PERIOD_CYC(MIN_PERIOD_CYC),
      .MISS_EDGES(MISS_EDGES),
      .RECOVER_EDGES(RECOVER_EDGES),
      .SPIKE_LIMIT(SPIKE_LIMIT)
   ) u_monitor (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .guard_en_i(guard_en_q),
      .freeze_i(halt_q),
      .main_rise_i(pin_rise[0]),
      .backup_rise_i(pin_rise[1]),
      .core_tick_o(core_tick_o),
      .src_o(src),
      .blocked_o(blocked),
      .enter_backup_o(ev_enter),
      .leave_backup_o(ev_leave),
      .block_start_o(ev_block)
   );

   assign core_clk_sel_o = src;
   assign filter_active_o = blocked;

   // ----------------------------------------------------------------------------
   // Wishbone decode
   // ----------------------------------------------------------------------------
   logic acc;
   logic hit_status;
   logic hit_event;
   logic hit_mask;
   logic wr_lane0;
   logic wr_status;
   logic rd_status;
   logic wr_event;
   logic wr_mask;

   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_status = wb_adr_i[9:2] == `CGRS_STATUS_IDX;
   assign hit_event = wb_adr_i[9:2] == `CGRS_EVENT_IDX;
   assign hit_mask = wb_adr_i[9:2] == `CGRS_MASK_IDX;
   assign wr_lane0 = acc & wb_we_i & wb_sel_i[0] & ~halt_q;
   assign wr_status = wr_lane0 & hit_status;
   assign rd_status = acc & ~wb_we_i & hit_status & ~halt_q;
   assign wr_event = wr_lane0 & hit_event;
   assign wr_mask = wr_lane0 & hit_mask;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc;
      end
   end

   // ----------------------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------------------
   logic irq_en_q;
   logic bk_active_q;
   logic lvd_flag_q;
   logic wdg_flag_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= 1'b0;
      end else if (wr_status) begin
         irq_en_q <= wb_dat_i[`CGRS_BIT_IE];
      end
   end

   // Set wins over the read clear
   always_ff @(posedge clk_i) begin
      if (rst_i || !guard_en_q) begin
         bk_active_q <= 1'b0;
      end else if (!halt_q) begin
         if (ev_enter) begin
            bk_active_q <= 1'b1;
         end else if (rd_status && src == cgrs_pkg::CGRS_ON_MAIN) begin
            bk_active_q <= 1'b0;
         end
      end
   end

   // Kept through pin and watchdog resets
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         if (lvd_reset_i && lvd_option_i) begin
            lvd_flag_q <= 1'b1;
         end
      end else if (wr_status && !wb_dat_i[`CGRS_BIT_LVD]) begin
         lvd_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         if (lvd_reset_i) begin
            wdg_flag_q <= 1'b0;
         end else begin
            wdg_flag_q <= wdg_reset_i;
         end
      end else if (wr_status && !wb_dat_i[`CGRS_BIT_WDG]) begin
         wdg_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Event status and mask
   // ----------------------------------------------------------------------------
   logic [`CGRS_EV_W-1:0] ev_set;
   logic [`CGRS_EV_W-1:0] ev_status_q;
   logic [`CGRS_EV_W-1:0] ev_mask_q;

   assign ev_set = {ev_block, ev_leave, ev_enter};

   // Write one clears; a new event in the same cycle stays set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_status_q <= `CGRS_EVENT_RST;
      end else if (wr_event) begin
         ev_status_q <= (ev_status_q & ~wb_dat_i[`CGRS_EV_W-1:0]) | ev_set;
      end else begin
         ev_status_q <= ev_status_q | ev_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_mask_q <= `CGRS_MASK_RST;
      end else if (wr_mask) begin
         ev_mask_q <= wb_dat_i[`CGRS_EV_W-1:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------------
   logic [7:0] status_val;
   logic [31:0] rd_d;

   always_comb begin
      status_val = 8'h00;
      status_val[`CGRS_BIT_LVD] = lvd_flag_q;
      status_val[`CGRS_BIT_IE] = irq_en_q;
      status_val[`CGRS_BIT_BKACT] = bk_active_q;
      status_val[`CGRS_BIT_WDG] = wdg_flag_q;
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit_status) begin
         rd_d[7:0] = status_val;
      end else if (hit_event) begin
         rd_d[`CGRS_EV_W-1:0] = ev_status_q;
      end else if (hit_mask) begin
         rd_d[`CGRS_EV_W-1:0] = ev_mask_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (acc && !wb_we_i) begin
         wb_dat_o <= rd_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt and wake
   // ----------------------------------------------------------------------------
   logic irq_src;
   logic irq_d;

   assign irq_src = (bk_active_q & irq_en_q) | (|(ev_status_q & ev_mask_q));
   assign irq_d = irq_src & ~cpu_irq_mask_i & ~halt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_d;
      end
   end

   // Wakes from wait only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= irq_src & wait_mode_i & ~halt_mode_i & ~halt_q;
      end
   end

endmodule : cgrs_top

`default_nettype wire

// file: tb/cgrs_osc_model.sv
// Main and backup oscillator pin model
`default_nettype none

module cgrs_osc_model (
   // Clock
   input wire logic clk_i,
   // Control: 0 stopped, 1 steady, 2 spiky
   input wire logic [1:0] mode_i,
   input wire logic backup_en_i,
   // Oscillator pins
   output logic main_osc_o,
   output logic backup_osc_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0] main_cnt_q;
   logic [4:0] bk_cnt_q;

   initial begin
      main_osc_o = 1'b0;
      backup_osc_o = 1'b0;
      main_cnt_q = 5'h00;
      bk_cnt_q = 5'h00;
   end

   // Stopped main holds its level, as a dead resonator would
   always @(posedge clk_i) begin
      main_cnt_q <= main_cnt_q + 5'h01;
      if ((mode_i == 2'h1 && main_cnt_q >= 5'h05) || (mode_i == 2'h2 && main_cnt_q >= 5'h01)) begin
         main_cnt_q <= 5'h00;
         main_osc_o <= ~main_osc_o;
      end
   end

   // Backup runs only while enabled
   always @(posedge clk_i) begin
      if (backup_en_i) begin
         bk_cnt_q <= (bk_cnt_q >= 5'h13) ? 5'h00 : bk_cnt_q + 5'h01;
         if (bk_cnt_q >= 5'h13) backup_osc_o <= ~backup_osc_o;
      end
   end
endmodule : cgrs_osc_model

`default_nettype wire

// file: tb/cgrs_props.sv
// Port checker for the clock guard and reset status block
`default_nettype none
`include "cgrs_cfg.svh"

module cgrs_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Options and CPU state
   input wire logic guard_option_i,
   input wire logic cpu_irq_mask_i,
   input wire logic wait_mode_i,
   input wire logic halt_mode_i,
   // Outputs watched
   input wire logic core_clk_sel_o,
   input wire logic filter_active_o,
   input wire logic backup_osc_en_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic guard_q;
   logic rd_q;

   // ----------------------------------------
   // Option latch and status read tracker
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) guard_q <= guard_option_i;
   end
   always_ff @(posedge clk_i) begin
      rd_q <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
         && (wb_adr_i[9:2] == `CGRS_STATUS_IDX);
   end

   a_irq_cpu_unmasked: assert property (irq_o |-> !$past(cpu_irq_mask_i))
      else $error("irq raised while the cpu mask was set");
   a_irq_not_halt: assert property (irq_o |-> !$past(halt_mode_i, 2))
      else $error("irq raised while halted");
   a_wake_in_wait: assert property (wake_o |-> $past(wait_mode_i) && !$past(halt_mode_i))
      else $error("wake outside wait or during halt");
   a_backup_osc_halt: assert property ($past(halt_mode_i) |-> !backup_osc_en_o)
      else $error("backup oscillator left on in halt");
   a_guard_off_main: assert property (!guard_q |-> !core_clk_sel_o && !backup_osc_en_o)
      else $error("backup used with the guard option off");
   a_guard_off_flag: assert property (rd_q && wb_ack_o && !guard_q |-> !wb_dat_o[1])
      else $error("backup flag read as one with the guard option off");
   a_reserved_zero: assert property (rd_q && wb_ack_o |->
      wb_dat_o[7:5] == 3'h0 && !wb_dat_o[3] && wb_dat_o[31:8] == 24'h0)
      else $error("reserved status bits not zero");
   a_backup_needs_guard: assert property ($rose(core_clk_sel_o) |->
      guard_q && backup_osc_en_o)
      else $error("switch to backup without guard or backup oscillator");

   c_on_backup_irq: cover property (core_clk_sel_o && irq_o);
   c_wake: cover property (wake_o);
   c_filter: cover property (filter_active_o);
endmodule : cgrs_props

bind cgrs_top cgrs_props cgrs_props_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .guard_option_i(guard_option_i), .cpu_irq_mask_i(cpu_irq_mask_i),
   .wait_mode_i(wait_mode_i), .halt_mode_i(halt_mode_i),
   .core_clk_sel_o(core_clk_sel_o), .filter_active_o(filter_active_o),
   .backup_osc_en_o(backup_osc_en_o), .irq_o(irq_o), .wake_o(wake_o)
);

`default_nettype wire

// file: tb/clock_guard_reset_status_tb.sv
// Self-checking bench for the clock guard and reset status block
`default_nettype none
`include "cgrs_cfg.svh"

module clock_guard_reset_status_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, main_osc, backup_osc, core_tick_o, core_clk_sel_o;
   logic filter_active_o, backup_osc_en_o, irq_o, wake_o;
   logic guard_option_i = 1'b1;
   logic lvd_reset_i = 1'b0;
   logic wdg_reset_i = 1'b0;
   logic cpu_irq_mask_i = 1'b1;
   logic wait_mode_i = 1'b0;
   logic halt_mode_i = 1'b0;
   logic [1:0] osc_mode = 2'h1;
   logic [31:0] scratch;
   int error_cnt = 0;
   int check_count = 0;

   always #4 clk_i = ~clk_i;

   cgrs_top cgrs_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_osc_i(main_osc),
      .backup_osc_i(backup_osc), .guard_option_i(guard_option_i), .lvd_option_i(1'b1),
      .lvd_reset_i(lvd_reset_i), .wdg_reset_i(wdg_reset_i), .cpu_irq_mask_i(cpu_irq_mask_i),
      .wait_mode_i(wait_mode_i), .halt_mode_i(halt_mode_i), .core_tick_o(core_tick_o),
      .core_clk_sel_o(core_clk_sel_o), .filter_active_o(filter_active_o),
      .backup_osc_en_o(backup_osc_en_o), .irq_o(irq_o), .wake_o(wake_o)
   );

   cgrs_osc_model cgrs_osc_model_i (
      .clk_i(clk_i), .mode_i(osc_mode), .backup_en_i(backup_osc_en_o),
      .main_osc_o(main_osc), .backup_osc_o(backup_osc)
   );

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   task automatic chk1(input logic exp, input logic got);
      chk({31'h0, exp}, {31'h0, got});
   endtask : chk1

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc

   // Core ticks seen in a window of 120 cycles
   task automatic tick_chk(input int exp);
      int n;
      n = 0;
      repeat (120) begin
         @(posedge clk_i);
         if (core_tick_o === 1'b1) n++;
      end
      chk(exp, n);
   endtask : tick_chk

   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= {24'h0, wd};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      scratch = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         close_out();
      end
   endtask : xfer

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk({24'h0, exp}, scratch);
   endtask : rd_chk

   task automatic do_reset(input logic g, input logic undervoltage_detector, input logic wdg);
      @(posedge clk_i);
      rst_i <= 1'b1;
      guard_option_i <= g;
      lvd_reset_i <= undervoltage_detector;
      wdg_reset_i <= wdg;
      cyc(12);
      rst_i <= 1'b0;
      lvd_reset_i <= 1'b0;
      wdg_reset_i <= 1'b0;
   endtask : do_reset

   // Which 0 waits on clock select, 1 on filter
   task automatic wait_for(input int which, input logic val);
      int n;
      n = 0;
      while (n < 3000 && (which == 0 ? core_clk_sel_o : filter_active_o) !== val) begin
         @(posedge clk_i);
         n++;
      end
      chk1(val, which == 0 ? core_clk_sel_o : filter_active_o);
      if (n >= 3000) close_out();
   endtask : wait_for

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Kind 0 writes, 1 pin reset, 2 watchdog reset, 3 undervoltage reset
   task automatic t_reset_cause();
      logic [1:0] k [11] = '{3, 2, 0, 1, 2, 3, 0, 0, 1, 2, 0};
      logic [7:0] d [11] = '{0, 0, 8'h10, 0, 0, 0, 0, 8'h04, 0, 0, 0};
      logic [7:0] e [11] = '{8'h10, 8'h11, 8'h10, 8'h10, 8'h11, 8'h10, 0, 8'h04, 0, 8'h01, 0};
      for (int i = 0; i < 11; i++) begin
         if (k[i] == 2'h0) xfer(1'b1, `CGRS_STATUS_IDX, d[i]);
         else do_reset(1'b1, k[i] == 2'h3, k[i] == 2'h2);
         rd_chk(`CGRS_STATUS_IDX, e[i]);
      end
      rd_chk(8'h30, 8'h00);
      $display("test reset_cause done");
   endtask : t_reset_cause

   task automatic t_backup();
      xfer(1'b1, `CGRS_STATUS_IDX, 8'h04);
      osc_mode <= 2'h0;
      wait_for(0, 1'b1);
      rd_chk(`CGRS_STATUS_IDX, 8'h06);
      rd_chk(`CGRS_STATUS_IDX, 8'h06);
      cyc(3);
      chk1(1'b0, irq_o);
      cpu_irq_mask_i <= 1'b0;
      cyc(3);
      chk1(1'b1, irq_o);
      wait_mode_i <= 1'b1;
      cyc(3);
      chk1(1'b1, wake_o);
      halt_mode_i <= 1'b1;
      cyc(3);
      chk1(1'b0, wake_o);
      chk1(1'b0, backup_osc_en_o);
      xfer(1'b1, `CGRS_STATUS_IDX, 8'h00);
      halt_mode_i <= 1'b0;
      wait_mode_i <= 1'b0;
      cyc(3);
      chk1(1'b1, irq_o);
      rd_chk(`CGRS_STATUS_IDX, 8'h06);
      osc_mode <= 2'h1;
      wait_for(0, 1'b0);
      rd_chk(`CGRS_STATUS_IDX, 8'h06);
      rd_chk(`CGRS_STATUS_IDX, 8'h04);
      cyc(2);
      chk1(1'b0, irq_o);
      rd_chk(`CGRS_EVENT_IDX, 8'h03);
      xfer(1'b1, `CGRS_EVENT_IDX, 8'h07);
      rd_chk(`CGRS_EVENT_IDX, 8'h00);
      cpu_irq_mask_i <= 1'b1;
      $display("test backup done");
   endtask : t_backup

   task automatic t_spike();
      xfer(1'b1, `CGRS_STATUS_IDX, 8'h00);
      xfer(1'b1, `CGRS_MASK_IDX, 8'h04);
      cpu_irq_mask_i <= 1'b0;
      osc_mode <= 2'h2;
      wait_for(1, 1'b1);
      cyc(4);
      chk1(1'b1, irq_o);
      osc_mode <= 2'h1;
      wait_for(1, 1'b0);
      wait_for(0, 1'b0);
      xfer(1'b0, `CGRS_EVENT_IDX, 8'h00);
      chk1(1'b1, scratch[2]);
      xfer(1'b1, `CGRS_EVENT_IDX, 8'h07);
      cyc(2);
      chk1(1'b0, irq_o);
      xfer(1'b0, `CGRS_STATUS_IDX, 8'h00);
      tick_chk(10);
      xfer(1'b1, `CGRS_MASK_IDX, 8'h00);
      cpu_irq_mask_i <= 1'b1;
      $display("test spike done");
   endtask : t_spike

   task automatic t_guard_off();
      do_reset(1'b0, 1'b0, 1'b0);
      osc_mode <= 2'h0;
      cyc(300);
      chk1(1'b0, core_clk_sel_o);
      rd_chk(`CGRS_STATUS_IDX, 8'h00);
      osc_mode <= 2'h1;
      cyc(30);
      tick_chk(10);
      $display("test guard_off done");
   endtask : t_guard_off

   initial begin
      t_reset_cause();
      t_backup();
      t_spike();
      t_guard_off();
      close_out();
   end
endmodule : clock_guard_reset_status_tb

`default_nettype wire
